// ### common/prc_params.svh
// constants for the priority resolver command core
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

// port select values
`define PRC_SEL_CMD       1'b0
`define PRC_SEL_MASK      1'b1

// command word bit positions
`define PRC_B_ROTATE      7
`define PRC_B_LVL_SEL     6
`define PRC_B_EOI         5
`define PRC_B_INIT        4
`define PRC_B_MODE        3
`define PRC_B_SMM_WE      6
`define PRC_B_SMM_SEL     5
`define PRC_B_POLL        2
`define PRC_B_RD_REG      1
`define PRC_B_RD_SEL      0
`define PRC_LVL_HI        2
`define PRC_LVL_LO        0

// reset and fixed values
`define PRC_MASK_RST      8'h00
`define PRC_ISR_RST       8'h00
`define PRC_IRR_RST       8'h00
`define PRC_LOWEST_RST    3'h7
`define PRC_DFLT_LEVEL    3'h7
`define PRC_RANK_NONE     4'h8
`define PRC_LVL_ONE       3'h1
`define PRC_POLL_PAD      4'h0

`endif

// ### common/prc_pkg.sv
// types shared by the priority resolver command core
package prc_pkg;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       port_select;
      logic [7:0] data;
   } prc_bus_req_t;

   typedef struct packed {
      logic       valid;
      logic       oe;
      logic [7:0] data;
   } prc_bus_rsp_t;

   typedef struct packed {
      logic       valid;
      logic       dflt;
      logic [2:0] level;
   } prc_vec_t;

   typedef enum logic [1:0] {
      PRC_ACK_IDLE,
      PRC_ACK_SECOND,
      PRC_ACK_THIRD
   } prc_ack_t;

   typedef enum logic [2:0] {
      PRC_OP_CLR_ROT_AUTO,
      PRC_OP_NSP_EOI,
      PRC_OP_NOP,
      PRC_OP_SPEC_EOI,
      PRC_OP_SET_ROT_AUTO,
      PRC_OP_ROT_NSP_EOI,
      PRC_OP_SET_PRIO,
      PRC_OP_ROT_SPEC_EOI
   } prc_op_t;

endpackage

// ### dv/prc_core_chk.sv
// assertion checker for the priority resolver command core
`timescale 1ns/100ps
`default_nettype none
module prc_core_chk (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  ce,
   input wire prc_pkg::prc_bus_req_t bus_req,
   input wire prc_pkg::prc_bus_rsp_t bus_rsp,
   input wire logic                  acknowledge_strobe,
   input wire logic [7:0]            request_inputs,
   input wire logic                  auto_end_mode,
   input wire logic                  two_cycle_mode,
   input wire logic                  int_req,
   input wire prc_pkg::prc_vec_t     vector,
   input wire logic [7:0]            in_service
);
   // ****************************************
   // mask shadow and reset history
   // ****************************************
   logic [7:0] mask_ff;
   logic [7:0] nxt_mask;
   logic       rstq_ff;
   wire logic  cmd_wr = ce && bus_req.wr && !bus_req.port_select && (bus_req.data[4:3] == 2'h0);
   wire logic  eoi_wr = cmd_wr && bus_req.data[5];
   always_comb begin
      nxt_mask = mask_ff;
      if (ce && bus_req.wr && bus_req.port_select) begin
         nxt_mask = bus_req.data;
      end else if (ce && bus_req.wr && bus_req.data[4]) begin
         nxt_mask = 8'h00;
      end
   end
   always_ff @(posedge clk) begin
      mask_ff <= rst ? 8'h00 : nxt_mask;
      rstq_ff <= rst;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_RSP_LAT: assert property (ce && bus_req.rd |=> bus_rsp.valid && bus_rsp.oe)
      else $error("read strobe without answer one cycle later");
   AST_MASK_RD: assert property (
      ce && bus_req.rd && bus_req.port_select |=> bus_rsp.data == $past(mask_ff))
      else $error("mask port read does not return the mask");
   AST_MASK_ALL: assert property (mask_ff == 8'hff |-> !int_req)
      else $error("interrupt raised with every channel masked");
   AST_VEC_CAUSE: assert property (
      vector.valid |-> $past(ce && (acknowledge_strobe || bus_req.rd)))
      else $error("vector without acknowledge");
   AST_VEC_ISR: assert property (
      vector.valid && !vector.dflt |-> in_service[vector.level])
      else $error("acknowledged level not in service");
   AST_ISR_SET: assert property (
      !rstq_ff && |(in_service & ~$past(in_service))
      |-> $past(ce && (acknowledge_strobe || bus_req.rd)))
      else $error("in-service bit set without acknowledge");
   AST_ISR_CLR: assert property (
      !rstq_ff && |($past(in_service) & ~in_service)
      |-> $past(eoi_wr || (ce && acknowledge_strobe)))
      else $error("in-service bit cleared without end of service");
   AST_PRIO_KEEP: assert property (
      cmd_wr && bus_req.data[7:5] == 3'h6 && !acknowledge_strobe && !bus_req.rd
      |=> $stable(in_service))
      else $error("set priority changed in-service bits");
   AST_NOP_WORD: assert property (
      cmd_wr && bus_req.data[7:5] == 3'h2 && !acknowledge_strobe && !bus_req.rd
      |=> $stable(in_service))
      else $error("unassigned command changed in-service bits");
   cover property (vector.valid && !vector.dflt);
   cover property (vector.valid && vector.dflt);
   cover property (ce && bus_req.rd && !bus_req.port_select);
   cover property ($rose(int_req) && |in_service);
endmodule
bind prc_core prc_core_chk prc_core_chk_i (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req),
   .bus_rsp(bus_rsp), .acknowledge_strobe(acknowledge_strobe), .request_inputs(request_inputs),
   .auto_end_mode(auto_end_mode), .two_cycle_mode(two_cycle_mode), .int_req(int_req),
   .vector(vector), .in_service(in_service));
`default_nettype wire

// ### dv/prc_host.sv
// host processor model: command port cycles and acknowledge strobes
`timescale 1ns/100ps
`default_nettype none
module prc_host (
   input  wire logic                  clk,
   output prc_pkg::prc_bus_req_t      bus_req,
   input  wire prc_pkg::prc_bus_rsp_t bus_rsp,
   output logic                       acknowledge_strobe,
   input  wire prc_pkg::prc_vec_t     vector
);
   // ****************************************
   // bus cycles
   // ****************************************
   initial begin
      bus_req = 11'h000;
      acknowledge_strobe = 1'b0;
   end
   // released data lines show the inverse of the last value
   task automatic wr_word(input logic ps, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, port_select: ps, data: d};
      @(posedge clk);
      bus_req <= '{wr: 1'b0, rd: 1'b0, port_select: ps, data: ~d};
   endtask
   task automatic rd_word(input logic ps, output logic [9:0] r);
      @(posedge clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, port_select: ps, data: bus_req.data};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 r = {bus_rsp.valid, bus_rsp.oe, bus_rsp.data};
   endtask
   // lone device: n acknowledge strobes, vector captured after the first, no slave copy
   task automatic ack_seq(input int n, output prc_pkg::prc_vec_t v);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         acknowledge_strobe <= 1'b1;
         @(posedge clk);
         acknowledge_strobe <= 1'b0;
         if (i == 0) #1 v = vector;
      end
   endtask
endmodule
`default_nettype wire

// ### dv/priority_resolver_command_logic_tb.sv
// testbench for the priority resolver command core
`timescale 1ns/100ps
`default_nettype none
module priority_resolver_command_logic_tb;
   // ****************************************
   // harness
   // ****************************************
   logic                  clk;
   logic                  rst;
   logic                  ce;
   prc_pkg::prc_bus_req_t bus_req;
   prc_pkg::prc_bus_rsp_t bus_rsp;
   logic                  ack;
   logic [7:0]            req_in;
   logic                  auto_end;
   logic                  two_cyc;
   logic                  int_req;
   prc_pkg::prc_vec_t     vector;
   prc_pkg::prc_vec_t     v;
   logic [7:0]            in_service;
   int                    n_fail;
   int                    tests_run;
   int                    cyc;
   prc_core prc_core_i (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .bus_rsp(bus_rsp),
      .acknowledge_strobe(ack), .request_inputs(req_in), .auto_end_mode(auto_end),
      .two_cycle_mode(two_cyc), .int_req(int_req), .vector(vector), .in_service(in_service));
   prc_host prc_host_i (.clk(clk), .bus_req(bus_req), .bus_rsp(bus_rsp),
      .acknowledge_strobe(ack), .vector(vector));
   always #10 clk = ~clk;
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         summarize();
      end
   end
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic ps, input logic [7:0] d);
      prc_host_i.wr_word(ps, d);
   endtask
   task automatic rdc(input logic ps, input logic [7:0] e);
      logic [9:0] r;
      prc_host_i.rd_word(ps, r);
      chk(r, {2'h3, e});
   endtask
   task automatic setreq(input logic [7:0] q);
      @(posedge clk);
      req_in <= q;
   endtask
   // new request levels take effect one edge before the first strobe
   task automatic ackc(input int n, input logic [2:0] lvl, input logic [7:0] nreq);
      prc_pkg::prc_vec_t w;
      setreq(nreq);
      prc_host_i.ack_seq(n, w);
      chk({5'h00, w}, {5'h00, 2'h2, lvl});
   endtask
   task automatic in_service_register(input logic [7:0] e);
      repeat (2) @(posedge clk);
      #1 chk({2'h0, in_service}, {2'h0, e});
   endtask
   task automatic irq(input logic e);
      repeat (3) @(posedge clk);
      #1 chk({9'h000, int_req}, {9'h000, e});
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      req_in = 8'h00;
      auto_end = 1'b0;
      two_cyc = 1'b1;
      n_fail = 0;
      tests_run = 0;
      cyc = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wr(1'b1, 8'ha5);
      rdc(1'b1, 8'ha5);
      wr(1'b0, 8'h10);
      rdc(1'b1, 8'h00);
      setreq(8'h28);
      irq(1'b1);
      ackc(2, 3'h3, 8'h20);
      in_service_register(8'h08);
      irq(1'b0);
      setreq(8'h21);
      irq(1'b1);
      ackc(2, 3'h0, 8'h20);
      wr(1'b0, 8'h20);
      in_service_register(8'h08);
      wr(1'b0, 8'h63);
      in_service_register(8'h00);
      wr(1'b1, 8'h20);
      irq(1'b0);
      wr(1'b1, 8'hff);
      irq(1'b0);
      wr(1'b1, 8'h00);
      irq(1'b1);
      setreq(8'h60);
      wr(1'b0, 8'h0e);
      rdc(1'b0, 8'h85);
      wr(1'b0, 8'h0a);
      rdc(1'b0, 8'h60);
      wr(1'b0, 8'h0b);
      rdc(1'b0, 8'h20);
      rdc(1'b0, 8'h20);
      wr(1'b0, 8'hc4);
      in_service_register(8'h20);
      wr(1'b0, 8'he5);
      in_service_register(8'h00);
      setreq(8'h41);
      ackc(2, 3'h6, 8'h01);
      wr(1'b0, 8'ha0);
      in_service_register(8'h00);
      ackc(2, 3'h0, 8'h00);
      wr(1'b0, 8'h40);
      in_service_register(8'h01);
      wr(1'b0, 8'h20);
      ackc(2, 3'h5, 8'h00);
      wr(1'b0, 8'h20);
      in_service_register(8'h00);
      wr(1'b0, 8'hc7);
      @(posedge clk);
      auto_end <= 1'b1;
      wr(1'b0, 8'h80);
      ackc(2, 3'h0, 8'h03);
      in_service_register(8'h00);
      ackc(2, 3'h1, 8'h03);
      wr(1'b0, 8'h00);
      ackc(2, 3'h0, 8'h03);
      ackc(2, 3'h0, 8'h03);
      @(posedge clk);
      two_cyc <= 1'b0;
      prc_host_i.ack_seq(2, v);
      in_service_register(8'h01);
      prc_host_i.ack_seq(1, v);
      in_service_register(8'h00);
      @(posedge clk);
      two_cyc <= 1'b1;
      auto_end <= 1'b0;
      ackc(2, 3'h0, 8'h03);
      irq(1'b0);
      wr(1'b0, 8'h68);
      irq(1'b1);
      ackc(2, 3'h1, 8'h03);
      wr(1'b1, 8'h01);
      wr(1'b0, 8'h20);
      in_service_register(8'h01);
      wr(1'b0, 8'h08);
      irq(1'b1);
      wr(1'b0, 8'h48);
      irq(1'b0);
      // acknowledge with the only unmasked request blocked by in-service level 0 gives the default level
      prc_host_i.ack_seq(2, v);
      chk({5'h00, v}, {5'h00, 2'h3, 3'h7});
      in_service_register(8'h01);
      // clock enable low: the mask write is not taken
      @(posedge clk);
      ce <= 1'b0;
      wr(1'b1, 8'h55);
      @(posedge clk);
      ce <= 1'b1;
      rdc(1'b1, 8'h01);
      summarize();
   end
endmodule
`default_nettype wire

// ### hdl/prc_core.sv
// command decoding and priority resolution core
//
// Functional notes
// - write at mask port loads all eight mask bits; one inhibits a channel
// - command word bits 7,6,5 are rotate, level select, end of interrupt
// - level field bits 2..0 name the level, used only with level select
// - special mask select is ignored when its write enable bit is zero
// - enabled select one enters special mask mode, zero leaves it
// - after init priorities are fixed, level 0 highest, level 7 lowest
// - acknowledge resolves highest pending request, gives vector, sets in-service bit
// - in-service bit holds until end of interrupt or automatic end
// - in-service level blocks equal and lower levels, higher still interrupt
// - non-specific end clears highest set in-service bit
// - specific end clears in-service bit named by level field
// - in special mask mode non-specific end skips masked levels
// - auto end mode ends service on last acknowledge, second or third
// - under rotation the serviced level becomes lowest priority
// - rotate on non-specific end clears highest and makes it lowest
// - rotate in auto mode set by 100, cleared by 000
// - set priority makes level lowest, in-service bits untouched
// - level above the lowest, wrapping 7 to 0, becomes highest
// - rotate on specific end clears given level and makes it lowest
// - mask bit n gates only request input n
// - special mask mode ignores in-service priority; masks and a level's own in-service bit inhibit
// - command port write with bit 4 set is first init word
// - read register bit picks request or in-service register for reads
// - read at mask port returns the mask register
// - poll bit turns next command port read into acknowledge
`timescale 1ns/100ps
`default_nettype none
`include "prc_params.svh"

module prc_core (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire prc_pkg::prc_bus_req_t bus_req,
   output prc_pkg::prc_bus_rsp_t      bus_rsp,
   input  wire logic                  acknowledge_strobe,
   input  wire logic [7:0]            request_inputs,
   input  wire logic                  auto_end_mode,
   input  wire logic                  two_cycle_mode,
   output logic                       int_req,
   output prc_pkg::prc_vec_t          vector,
   output logic [7:0]                 in_service
);

   // ************************************************************
   // helper functions
   // ************************************************************

   // rank 0 is the level just above the lowest one
   function automatic logic [3:0] first_rank(
      input logic [7:0] vec,
      input logic [2:0] lowest
   );
      logic [3:0] rank;
      logic [2:0] idx;
      rank = `PRC_RANK_NONE;
      idx  = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         idx = 3'(lowest + 3'(i) + `PRC_LVL_ONE);
         if (vec[idx]) begin
            rank = 4'(i);
         end
      end
      return rank;
   endfunction

   function automatic logic [2:0] rank_level(
      input logic [3:0] rank,
      input logic [2:0] lowest
   );
      return 3'(lowest + rank[2:0] + `PRC_LVL_ONE);
   endfunction

   function automatic logic [7:0] one_hot(input logic [2:0] level);
      return 8'h01 << level;
   endfunction

   // ************************************************************
   // state
   // ************************************************************

   logic [7:0]            mask_ff;
   logic [7:0]            isr_ff;
   logic [7:0]            irr_ff;
   logic [2:0]            lowest_ff;
   logic                  smm_ff;
   logic                  rot_auto_ff;
   logic                  rd_isr_ff;
   logic                  poll_ff;
   prc_pkg::prc_ack_t     ack_ff;
   prc_pkg::prc_bus_rsp_t rsp_ff;
   prc_pkg::prc_vec_t     vec_ff;

   logic [7:0]            nxt_mask;
   logic [7:0]            nxt_isr;
   logic [7:0]            nxt_irr;
   logic [2:0]            nxt_lowest;
   logic                  nxt_smm;
   logic                  nxt_rot_auto;
   logic                  nxt_rd_isr;
   logic                  nxt_poll;
   prc_pkg::prc_ack_t     nxt_ack;
   prc_pkg::prc_bus_rsp_t nxt_rsp;
   prc_pkg::prc_vec_t     nxt_vec;

   // ************************************************************
   // port decode
   // ************************************************************

   logic       wr_mask;
   logic       wr_init;
   logic       wr_eoi_cmd;
   logic       wr_mode_cmd;
   logic       rd_mask;
   logic       rd_cmd;
   logic       poll_rd;
   logic [2:0] lvl_field;

   assign wr_mask     = bus_req.wr && bus_req.port_select == `PRC_SEL_MASK;
   assign wr_init     = bus_req.wr && bus_req.port_select == `PRC_SEL_CMD
                        && bus_req.data[`PRC_B_INIT];
   assign wr_eoi_cmd  = bus_req.wr && bus_req.port_select == `PRC_SEL_CMD
                        && !bus_req.data[`PRC_B_INIT]
                        && !bus_req.data[`PRC_B_MODE];
   assign wr_mode_cmd = bus_req.wr && bus_req.port_select == `PRC_SEL_CMD
                        && !bus_req.data[`PRC_B_INIT]
                        && bus_req.data[`PRC_B_MODE];
   assign rd_mask     = bus_req.rd && bus_req.port_select == `PRC_SEL_MASK;
   assign rd_cmd      = bus_req.rd && bus_req.port_select == `PRC_SEL_CMD;
   assign poll_rd     = rd_cmd && poll_ff;
   assign lvl_field   = bus_req.data[`PRC_LVL_HI:`PRC_LVL_LO];

   // ************************************************************
   // priority resolution
   // ************************************************************

   logic [7:0] cand;
   logic [3:0] cand_rank;
   logic [3:0] isr_rank;
   logic [2:0] cand_lvl;
   logic       pend;
   logic [7:0] eoi_src;
   logic [3:0] eoi_rank;
   logic [2:0] eoi_lvl;
   logic       eoi_any;

   // each mask bit gates only its own input
   assign cand      = irr_ff & ~mask_ff & (smm_ff ? ~isr_ff : 8'hff);
   assign cand_rank = first_rank(cand, lowest_ff);
   assign isr_rank  = first_rank(isr_ff, lowest_ff);
   assign cand_lvl  = rank_level(cand_rank, lowest_ff);
   assign pend      = smm_ff ? (cand_rank != `PRC_RANK_NONE)
                             : (cand_rank < isr_rank);

   // masked levels are skipped by a non-specific end in special mask mode
   assign eoi_src  = smm_ff ? (isr_ff & ~mask_ff) : isr_ff;
   assign eoi_rank = first_rank(eoi_src, lowest_ff);
   assign eoi_lvl  = rank_level(eoi_rank, lowest_ff);
   assign eoi_any  = eoi_rank != `PRC_RANK_NONE;

   // ************************************************************
   // next state
   // ************************************************************

   always_comb begin
      logic [7:0] isr_set;
      logic [7:0] isr_clr;
      logic [7:0] irr_clr;
      logic       take;
      logic       last_ack;
      logic       nsp_eoi;
      logic       nsp_rot;
      isr_set      = 8'h00;
      isr_clr      = 8'h00;
      irr_clr      = 8'h00;
      take         = (acknowledge_strobe && ack_ff == prc_pkg::PRC_ACK_IDLE) || poll_rd;
      last_ack     = 1'b0;
      nsp_eoi      = 1'b0;
      nsp_rot      = 1'b0;
      nxt_mask     = mask_ff;
      nxt_lowest   = lowest_ff;
      nxt_smm      = smm_ff;
      nxt_rot_auto = rot_auto_ff;
      nxt_rd_isr   = rd_isr_ff;
      nxt_poll     = poll_ff;
      nxt_ack      = ack_ff;
      nxt_rsp      = '0;
      nxt_vec      = '0;

      // freeze and take the winning request
      if (take) begin
         if (pend) begin
            isr_set = one_hot(cand_lvl);
            irr_clr = one_hot(cand_lvl);
         end
      end
      if (acknowledge_strobe && ack_ff == prc_pkg::PRC_ACK_IDLE) begin
         nxt_vec.valid = 1'b1;
         nxt_vec.dflt  = !pend;
         nxt_vec.level = pend ? cand_lvl : `PRC_DFLT_LEVEL;
      end

      // acknowledge sequence, two or three strobes
      if (acknowledge_strobe) begin
         unique case (ack_ff)
            prc_pkg::PRC_ACK_IDLE: begin
               nxt_ack = prc_pkg::PRC_ACK_SECOND;
            end
            prc_pkg::PRC_ACK_SECOND: begin
               if (two_cycle_mode) begin
                  last_ack = 1'b1;
                  nxt_ack  = prc_pkg::PRC_ACK_IDLE;
               end else begin
                  nxt_ack  = prc_pkg::PRC_ACK_THIRD;
               end
            end
            prc_pkg::PRC_ACK_THIRD: begin
               last_ack = 1'b1;
               nxt_ack  = prc_pkg::PRC_ACK_IDLE;
            end
            default: begin
               nxt_ack = prc_pkg::PRC_ACK_IDLE;
            end
         endcase
      end

      // automatic end on the last strobe
      if (last_ack && auto_end_mode) begin
         nsp_eoi = 1'b1;
         nsp_rot = rot_auto_ff;
      end

      // mask command word
      if (wr_mask) begin
         nxt_mask = bus_req.data;
      end

      // end of service and rotate command word
      if (wr_eoi_cmd) begin
         unique case (prc_pkg::prc_op_t'({bus_req.data[`PRC_B_ROTATE],
                                           bus_req.data[`PRC_B_LVL_SEL],
                                           bus_req.data[`PRC_B_EOI]}))
            prc_pkg::PRC_OP_NSP_EOI: begin
               nsp_eoi = 1'b1;
            end
            prc_pkg::PRC_OP_ROT_NSP_EOI: begin
               nsp_eoi = 1'b1;
               nsp_rot = 1'b1;
            end
            prc_pkg::PRC_OP_SPEC_EOI: begin
               isr_clr = isr_clr | one_hot(lvl_field);
            end
            prc_pkg::PRC_OP_ROT_SPEC_EOI: begin
               isr_clr    = isr_clr | one_hot(lvl_field);
               nxt_lowest = lvl_field;
            end
            prc_pkg::PRC_OP_SET_PRIO: begin
               nxt_lowest = lvl_field;
            end
            prc_pkg::PRC_OP_SET_ROT_AUTO: begin
               nxt_rot_auto = 1'b1;
            end
            prc_pkg::PRC_OP_CLR_ROT_AUTO: begin
               nxt_rot_auto = 1'b0;
            end
            prc_pkg::PRC_OP_NOP: begin
               nxt_rot_auto = rot_auto_ff;
            end
         endcase
      end

      // shared non-specific end, optionally rotating
      if (nsp_eoi && eoi_any) begin
         isr_clr = isr_clr | one_hot(eoi_lvl);
         if (nsp_rot) begin
            nxt_lowest = eoi_lvl;
         end
      end

      // mode and read command word
      if (wr_mode_cmd) begin
         if (bus_req.data[`PRC_B_SMM_WE]) begin
            nxt_smm = bus_req.data[`PRC_B_SMM_SEL];
         end
         if (bus_req.data[`PRC_B_RD_REG]) begin
            nxt_rd_isr = bus_req.data[`PRC_B_RD_SEL];
         end
         nxt_poll = bus_req.data[`PRC_B_POLL];
      end

      // register reads and poll answer
      if (rd_mask) begin
         nxt_rsp.valid = 1'b1;
         nxt_rsp.oe    = 1'b1;
         nxt_rsp.data  = mask_ff;
      end else if (poll_rd) begin
         nxt_rsp.valid = 1'b1;
         nxt_rsp.oe    = 1'b1;
         nxt_rsp.data  = {pend, `PRC_POLL_PAD, cand_lvl};
         nxt_poll      = 1'b0;
      end else if (rd_cmd) begin
         nxt_rsp.valid = 1'b1;
         nxt_rsp.oe    = 1'b1;
         nxt_rsp.data  = rd_isr_ff ? isr_ff : irr_ff;
      end

      // first init word restores defaults
      if (wr_init) begin
         nxt_mask     = `PRC_MASK_RST;
         nxt_lowest   = `PRC_LOWEST_RST;
         nxt_smm      = 1'b0;
         nxt_rot_auto = 1'b0;
         nxt_rd_isr   = 1'b0;
         nxt_poll     = 1'b0;
      end

      // set wins over clear on the same bit
      nxt_isr = (isr_ff & ~isr_clr) | isr_set;
      nxt_irr = (irr_ff & ~irr_clr) | request_inputs;
   end

   // ************************************************************
   // registers
   // ************************************************************

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_ff     <= `PRC_MASK_RST;
         isr_ff      <= `PRC_ISR_RST;
         irr_ff      <= `PRC_IRR_RST;
         lowest_ff   <= `PRC_LOWEST_RST;
         smm_ff      <= 1'b0;
         rot_auto_ff <= 1'b0;
         rd_isr_ff   <= 1'b0;
         poll_ff     <= 1'b0;
         ack_ff      <= prc_pkg::PRC_ACK_IDLE;
         rsp_ff      <= '0;
         vec_ff      <= '0;
      end else if (ce) begin
         mask_ff     <= nxt_mask;
         isr_ff      <= nxt_isr;
         irr_ff      <= nxt_irr;
         lowest_ff   <= nxt_lowest;
         smm_ff      <= nxt_smm;
         rot_auto_ff <= nxt_rot_auto;
         rd_isr_ff   <= nxt_rd_isr;
         poll_ff     <= nxt_poll;
         ack_ff      <= nxt_ack;
         rsp_ff      <= nxt_rsp;
         vec_ff      <= nxt_vec;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************

   assign int_req    = pend;
   assign bus_rsp    = rsp_ff;
   assign vector     = vec_ff;
   assign in_service = isr_ff;

endmodule

`default_nettype wire
